// ===== hw/asf_consts.svh
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH

// register byte offsets
`define ASF_OFF_AUDIO_CONTROL  8'h00
`define ASF_OFF_DATA           8'h04
`define ASF_OFF_STATUS         8'h08
`define ASF_OFF_PRESCALE       8'h0C

// audio_control_register fields
`define ASF_CTL_ENABLE          0
`define ASF_CTL_STANDARD_SELECT 1
`define ASF_CTL_DATA_LENGTH     3
`define ASF_CTL_CHANNEL_LENGTH  5
`define ASF_CTL_CLOCK_POLARITY  6
`define ASF_CTL_PCM_SYNC_MODE   7
`define ASF_CTL_MASTER          8
`define ASF_CTL_TRANSMIT        9
`define ASF_CTL_MCLK_ENABLE     10
`define ASF_CTL_WIDTH           11

// data_length_field encodings
`define ASF_DTL_16 2'h0
`define ASF_DTL_24 2'h1
`define ASF_DTL_32 2'h2

// status register fields
`define ASF_ST_TX_EMPTY  0
`define ASF_ST_RX_FULL   1
`define ASF_ST_CHANNEL   2
`define ASF_ST_OVERRUN   3
`define ASF_ST_BUSY      4

// reset values
`define ASF_CTL_RST       11'h000
`define ASF_PRESCALE_RST  8'h03

// timing: master clock per sample, long sync width in bits
`define ASF_MCK_PER_FRAME  256
`define ASF_LONG_SYNC_BITS 13
// master clock ticks per bit clock half period
`define ASF_BCK_TICKS16 (`ASF_MCK_PER_FRAME / (2 * 16))
`define ASF_BCK_TICKS32 (`ASF_MCK_PER_FRAME / (2 * 32))

`endif

// ===== hw/asf_pkg.sv
package asf_pkg;

  typedef enum logic [1:0] {
    ASF_STD_CLASSIC = 2'h0,
    ASF_STD_MSBJ    = 2'h1,
    ASF_STD_LSBJ    = 2'h2,
    ASF_STD_PCM     = 2'h3
  } asf_std_t;

  typedef struct packed {
    logic serial_bit_clock;
    logic word_select;
    logic serial_data_line;
  } asf_pin_in_t;

  typedef struct packed {
    logic master_clock_out;
    logic master_clock_oe;
    logic serial_bit_clock;
    logic serial_bit_clock_oe;
    logic word_select;
    logic word_select_oe;
    logic serial_data_line;
    logic serial_data_line_oe;
  } asf_pin_out_t;

  typedef struct packed {
    logic [10:0] audio_control_register;
    logic [7:0]  prescale;
    logic [15:0] txbuf;
    logic [15:0] rxbuf;
    logic [15:0] txsh;
    logic [15:0] rxsh;
    logic        transmit_empty_flag;
    logic        receive_not_empty_flag;
    logic        channel_side_flag;
    logic        overrun;
    logic [7:0]  divcnt;
    logic [2:0]  tick;
    logic        mck;
    logic        lck;
    logic [2:0]  cks;
    logic [1:0]  wss;
    logic [1:0]  sds;
    logic [5:0]  pos;
    logic        started;
    logic        wsprev;
    logic        ck_o;
    logic        ck_oe;
    logic        ws_o;
    logic        ws_oe;
    logic        sd_o;
    logic        sd_oe;
    logic        mck_oe;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } asf_state_t;

endpackage

// ===== hw/asf_top.sv
`timescale 1ns/1ns
`include "asf_consts.svh"

module asf_top (
  input  logic                 pclk,
  input  logic                 presetn,
  input  logic                 psel,
  input  logic                 penable,
  input  logic                 pwrite,
  input  logic [7:0]           paddr,
  input  logic [31:0]          pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  asf_pkg::asf_pin_in_t pin_i,
  output asf_pkg::asf_pin_out_t pin_o
);
  import asf_pkg::*;

  localparam logic [2:0] TMAX16 = 3'(`ASF_BCK_TICKS16 - 1);
  localparam logic [2:0] TMAX32 = 3'(`ASF_BCK_TICKS32 - 1);
  localparam logic [4:0] LSYNC  = 5'(`ASF_LONG_SYNC_BITS);

  asf_state_t st_r;
  asf_state_t st_nxt;

  logic       en, mstr, txm, cl32, cpol, pcm, lsb, pcml, d16, d24;
  asf_std_t   stdsel;
  logic [1:0] dtl;
  logic [5:0] clen, last, np, np1, fpos, cpos;
  logic [4:0] nidx, cidx;
  logic       nchan, cchan, tw, bt, rise_e, fall_e, launch, capture;
  logic       wsc, algn, rxload, done;
  logic [31:0] rdata;

  // channel of a frame slot
  function automatic logic chan_f(input logic [5:0] p, input logic c32);
    return c32 ? p[5] : p[4];
  endfunction

  // bit index inside the channel slot
  function automatic logic [4:0] idx_f(input logic [5:0] p, input logic c32);
    return c32 ? p[4:0] : {1'b0, p[3:0]};
  endfunction

  // whether a channel half-word comes from / goes to the data buffer
  function automatic logic src_f(input logic h, input logic c32, input logic s16,
                                 input logic lj);
    if (!c32) begin
      return !h;
    end else if (s16) begin
      return lj ? h : !h;
    end
    return 1'b1;
  endfunction

  // data window inside the channel slot
  function automatic logic win_f(input logic [4:0] i, input logic c32, input logic s24,
                                 input logic lj);
    if (c32 && s24) begin
      return lj ? (i >= 5'h08) : (i < 5'h18);
    end
    return 1'b1;
  endfunction

  // configuration decode
  assign en     = st_r.audio_control_register[`ASF_CTL_ENABLE];
  assign stdsel = asf_std_t'(st_r.audio_control_register[`ASF_CTL_STANDARD_SELECT +: 2]);
  assign dtl    = st_r.audio_control_register[`ASF_CTL_DATA_LENGTH +: 2];
  assign cl32   = st_r.audio_control_register[`ASF_CTL_CHANNEL_LENGTH];
  assign cpol   = st_r.audio_control_register[`ASF_CTL_CLOCK_POLARITY];
  assign pcml   = st_r.audio_control_register[`ASF_CTL_PCM_SYNC_MODE];
  assign mstr   = st_r.audio_control_register[`ASF_CTL_MASTER];
  assign txm    = st_r.audio_control_register[`ASF_CTL_TRANSMIT];
  assign pcm    = (stdsel == ASF_STD_PCM);
  assign lsb    = (stdsel == ASF_STD_LSBJ);
  assign d24    = (dtl == `ASF_DTL_24);
  assign d16    = !d24 && (dtl != `ASF_DTL_32);
  assign clen   = cl32 ? 6'h20 : 6'h10;
  assign last   = cl32 ? 6'h3F : 6'h1F;

  // master clock tick and bit clock toggle
  assign tw = en && mstr && (st_r.divcnt == st_r.prescale);
  assign bt = tw && (st_r.tick == (cl32 ? TMAX32 : TMAX16));

  // logical bit clock edges, master or slave
  always_comb begin
    if (mstr) begin
      rise_e = en && bt && !st_r.lck;
      fall_e = en && bt && st_r.lck;
    end else begin
      rise_e = en && ((st_r.cks[1] ^ cpol) && !(st_r.cks[2] ^ cpol));
      fall_e = en && (!(st_r.cks[1] ^ cpol) && (st_r.cks[2] ^ cpol));
    end
  end
  assign launch  = pcm ? rise_e : fall_e;
  assign capture = pcm ? fall_e : rise_e;

  // next slot for launch
  assign np    = (st_r.pos == last) ? 6'h00 : 6'(st_r.pos + 6'h01);
  assign np1   = (np == last) ? 6'h00 : 6'(np + 6'h01);
  assign nidx  = idx_f(np, cl32);
  assign nchan = chan_f(np, cl32);

  // slave alignment on word_select at capture
  assign wsc  = st_r.wss[1];
  always_comb begin
    if (pcm) begin
      algn = !mstr && wsc && !st_r.wsprev;
      fpos = pcml ? 6'h00 : 6'(clen - 6'h01);
    end else begin
      algn = !mstr && (wsc != st_r.wsprev) && (st_r.started || !wsc);
      if (stdsel == ASF_STD_CLASSIC) begin
        fpos = wsc ? 6'(clen - 6'h01) : last;
      end else begin
        fpos = wsc ? clen : 6'h00;
      end
    end
  end
  assign cpos   = algn ? fpos : st_r.pos;
  assign cidx   = idx_f(cpos, cl32);
  assign cchan  = chan_f(cpos, cl32);
  assign rxload = capture && (algn || st_r.started) && !txm && (cidx[3:0] == 4'hF)
                  && src_f(cidx[4], cl32, d16, lsb) && !st_r.receive_not_empty_flag;

  // APB read mux and completion
  assign done = psel && penable && st_r.pready;
  always_comb begin
    case (paddr)
      `ASF_OFF_AUDIO_CONTROL: rdata = {21'h0, st_r.audio_control_register};
      `ASF_OFF_DATA:          rdata = {16'h0, st_r.rxbuf};
      `ASF_OFF_STATUS:        rdata = {27'h0, st_r.started, st_r.overrun,
                                       st_r.channel_side_flag,
                                       st_r.receive_not_empty_flag,
                                       st_r.transmit_empty_flag};
      `ASF_OFF_PRESCALE:      rdata = {24'h0, st_r.prescale};
      default:                rdata = 32'h0;
    endcase
  end

  // next state
  always_comb begin
    logic [15:0] v;
    logic        b;
    v = 16'h0;
    b = 1'b0;
    st_nxt = st_r;
    st_nxt.cks = {st_r.cks[1:0], pin_i.serial_bit_clock};
    st_nxt.wss = {st_r.wss[0], pin_i.word_select};
    st_nxt.sds = {st_r.sds[0], pin_i.serial_data_line};
    // bus answer one cycle into the access phase
    st_nxt.pready = 1'b0;
    if (psel && penable && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = (paddr != `ASF_OFF_AUDIO_CONTROL) && (paddr != `ASF_OFF_DATA) &&
                       (paddr != `ASF_OFF_STATUS) && (paddr != `ASF_OFF_PRESCALE);
      st_nxt.prdata  = rdata;
    end
    if (done && pwrite) begin
      case (paddr)
        `ASF_OFF_AUDIO_CONTROL: st_nxt.audio_control_register = pwdata[10:0];
        `ASF_OFF_STATUS:        if (pwdata[`ASF_ST_OVERRUN]) st_nxt.overrun = 1'b0;
        `ASF_OFF_PRESCALE:      st_nxt.prescale = pwdata[7:0];
        default:                st_nxt.prescale = st_nxt.prescale;
      endcase
    end
    if (done && !pwrite && (paddr == `ASF_OFF_DATA)) begin
      st_nxt.receive_not_empty_flag = 1'b0;
    end
    // master clock divider and bit clock generator
    if (en && mstr) begin
      if (tw) begin
        st_nxt.divcnt = 8'h00;
        st_nxt.mck    = !st_r.mck;
        st_nxt.tick   = bt ? 3'h0 : 3'(st_r.tick + 3'h1);
        st_nxt.lck    = bt ? !st_r.lck : st_r.lck;
      end else begin
        st_nxt.divcnt = 8'(st_r.divcnt + 8'h01);
      end
    end else begin
      st_nxt.divcnt = 8'h00;
      st_nxt.mck    = 1'b0;
      st_nxt.tick   = 3'h0;
      st_nxt.lck    = 1'b0;
    end
    // disabled: frame restarts, channel flag back to left
    // slot 6'h3F wraps to slot 0 for either channel length, so the first
    // launch opens the left channel even when the length changes with enable
    if (!en) begin
      st_nxt.pos               = 6'h3F;
      st_nxt.started           = 1'b0;
      st_nxt.channel_side_flag = 1'b0;
      st_nxt.wsprev            = wsc; // follows the idle line, no false edge
      st_nxt.ws_o              = 1'b0;
      st_nxt.sd_o              = 1'b0;
    end
    // capture edge: sample word_select and data
    if (capture) begin
      st_nxt.wsprev = wsc;
      st_nxt.pos    = cpos;
      if (algn) begin
        st_nxt.started = 1'b1;
      end
      if ((algn || st_r.started) && !txm) begin
        b = st_r.sds[1] && win_f(cidx, cl32, d24, lsb);
        st_nxt.rxsh = {st_r.rxsh[14:0], b};
        if ((cidx[3:0] == 4'hF) && src_f(cidx[4], cl32, d16, lsb)) begin
          if (st_r.receive_not_empty_flag) begin
            st_nxt.overrun = 1'b1;
          end else begin
            st_nxt.rxbuf                  = {st_r.rxsh[14:0], b};
            st_nxt.receive_not_empty_flag = 1'b1;
            st_nxt.channel_side_flag      = pcm ? 1'b0 : cchan;
          end
        end
      end
    end
    // launch edge: next slot, word_select and data out
    if (launch && (mstr || st_r.started)) begin
      st_nxt.started = 1'b1;
      st_nxt.pos     = np;
      if (mstr) begin
        case (stdsel)
          ASF_STD_CLASSIC: st_nxt.ws_o = chan_f(np1, cl32);
          ASF_STD_PCM:     st_nxt.ws_o = pcml ? (nidx < LSYNC) :
                                         (nidx == 5'(clen - 6'h01));
          default:         st_nxt.ws_o = nchan;
        endcase
      end
      if (txm) begin
        if (nidx[3:0] == 4'h0) begin
          if (src_f(nidx[4], cl32, d16, lsb)) begin
            v = st_r.transmit_empty_flag ? 16'h0 : st_r.txbuf;
            st_nxt.transmit_empty_flag = 1'b1;
            if (!pcm) begin
              st_nxt.channel_side_flag = (d16 || nidx[4]) ? !nchan : nchan;
            end
          end else begin
            v = 16'h0;
          end
        end else begin
          v = st_r.txsh;
        end
        st_nxt.sd_o = v[15] && win_f(nidx, cl32, d24, lsb);
        st_nxt.txsh = {v[14:0], 1'b0};
      end
    end
    // pin drivers
    st_nxt.ck_o   = (mstr && en && st_nxt.lck) ^ cpol;
    st_nxt.ck_oe  = en && mstr;
    st_nxt.ws_oe  = en && mstr;
    st_nxt.sd_oe  = en && txm;
    st_nxt.mck_oe = en && mstr && st_r.audio_control_register[`ASF_CTL_MCLK_ENABLE];
    // a new write is never lost to a same-cycle buffer move
    if (done && pwrite && (paddr == `ASF_OFF_DATA)) begin
      st_nxt.txbuf               = pwdata[15:0];
      st_nxt.transmit_empty_flag = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r                        <= '0;
      st_r.audio_control_register <= `ASF_CTL_RST;
      st_r.prescale               <= `ASF_PRESCALE_RST;
      st_r.transmit_empty_flag    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign prdata                    = st_r.prdata;
  assign pready                    = st_r.pready;
  assign pslverr                   = st_r.pslverr;
  assign pin_o.master_clock_out    = st_r.mck;
  assign pin_o.master_clock_oe     = st_r.mck_oe;
  assign pin_o.serial_bit_clock    = st_r.ck_o;
  assign pin_o.serial_bit_clock_oe = st_r.ck_oe;
  assign pin_o.word_select         = st_r.ws_o;
  assign pin_o.word_select_oe      = st_r.ws_oe;
  assign pin_o.serial_data_line    = st_r.sd_o;
  assign pin_o.serial_data_line_oe = st_r.sd_oe;

  // helper: master clock ticks per bit clock period
  logic [4:0] mcnt_r;
  logic       mvld_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcnt_r <= 5'h00;
      mvld_r <= 1'b0;
    end else if (!(en && mstr)) begin
      mcnt_r <= 5'h00;
      mvld_r <= 1'b0;
    end else if (rise_e) begin
      mcnt_r <= 5'h01;
      mvld_r <= 1'b1;
    end else if (tw) begin
      mcnt_r <= 5'(mcnt_r + 5'h01);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mck_ratio:
  assert property (rise_e && mstr && mvld_r |-> mcnt_r == (cl32 ? 5'h08 : 5'h10))
    else $error("master clock not 256 times sample rate");
  a_fall_launch:
  assert property (en && $past(en) && mstr && !pcm && $changed(st_r.ws_o) |-> $past(fall_e))
    else $error("word select moved off falling edge");
  a_rise_launch:
  assert property (en && $past(en) && pcm && txm && $changed(st_r.sd_o) |-> $past(rise_e))
    else $error("pcm data moved off rising edge");
  a_left_first:
  assert property (launch && mstr && !pcm && np == 6'h00 |=> !st_r.ws_o && !st_r.pos[4])
    else $error("frame does not open on left channel");
  a_ws_lead:
  assert property (launch && mstr && !pcm && np == 6'(clen - 6'h01)
                   |=> st_r.ws_o == (stdsel == ASF_STD_CLASSIC))
    else $error("word select lead wrong");
  a_zero_pad:
  assert property (launch && txm && d16 && cl32 && !lsb && nidx[4] |=> !st_r.sd_o)
    else $error("padding bit not zero");
  a_rx_msb24:
  assert property (rxload && d24 && cl32 && !lsb && cidx[4] |=> st_r.rxbuf[7:0] == 8'h00)
    else $error("24-bit low byte not zero");
  a_rx_lsb24:
  assert property (rxload && d24 && cl32 && lsb && !cidx[4] |=> st_r.rxbuf[15:8] == 8'h00)
    else $error("24-bit high byte not zero");
  a_rx_side:
  assert property (rxload && !pcm |=> st_r.receive_not_empty_flag
                   && st_r.channel_side_flag == $past(cchan))
    else $error("channel side flag wrong on receive");
  a_slave_pins:
  assert property (!mstr && !$past(mstr) |-> !st_r.ck_oe && !st_r.ws_oe && !st_r.mck_oe)
    else $error("slave drives clock pins");
  a_pcm_long:
  assert property ($fell(st_r.ws_o) && en && mstr && pcm && pcml
                   |-> idx_f(st_r.pos, cl32) == LSYNC)
    else $error("long sync width wrong");

  c_tx_lsb24: cover property (launch && txm && lsb && d24 && cl32 && nidx == 5'h10);
  c_slave_sync: cover property (capture && algn);
  c_overrun: cover property (capture && $rose(st_r.overrun));
  c_pcm_short: cover property (mstr && pcm && !pcml && $rose(st_r.ws_o));

endmodule

// ===== bench/asf_codec_model.sv
`timescale 1ns/1ns
// external codec: listens to a master, or clocks frames out as master
module asf_codec_model (
  input  wire logic pclk,
  input  wire logic bck,
  input  wire logic ws,
  input  wire logic sd,
  input  wire logic mck,
  output logic      p_bck,
  output logic      p_ws,
  output logic      p_sd
);
  logic sd_hist[$];
  logic ws_hist[$];
  logic samp_rise   = 1'b1;
  logic drv         = 1'b0;
  logic bck_q       = 1'b0;
  logic mck_q       = 1'b0;
  int   mck_cnt     = 0;
  int   mck_per_bit = 0;

  initial begin
    p_bck = 1'b0;
    p_ws  = 1'b1;
    p_sd  = 1'b0;
  end

  // sample on the listener edge, count master clocks per bit
  always @(negedge pclk) begin
    if (bck !== bck_q && bck === samp_rise) begin
      sd_hist.push_back(sd);
      ws_hist.push_back(ws);
    end
    if (mck === 1'b1 && mck_q !== 1'b1)
      mck_cnt++;
    if (bck === 1'b1 && bck_q !== 1'b1) begin
      mck_per_bit = mck_cnt;
      mck_cnt = 0;
    end
    bck_q = bck;
    mck_q = mck;
  end

  // a released data line keeps changing
  always @(posedge pclk) begin
    if (!drv)
      p_sd <= ~p_sd;
  end

  // one stereo frame as master, bits change on the falling edge
  task automatic send_frame(input logic [31:0] l, input logic [31:0] r);
    logic [63:0] f;
    f = {l, r};
    drv = 1'b1;
    #7;
    for (int i = 0; i < 64; i++) begin
      p_bck = 1'b0;
      p_ws  = (i >= 32);
      p_sd  = f[63 - i];
      #80;
      p_bck = 1'b1;
      #80;
    end
    p_bck = 1'b0;
    drv = 1'b0;
  endtask
endmodule

// ===== bench/asf_top_test.sv
`timescale 1ns/1ns
`include "asf_consts.svh"
module asf_top_test;
  import asf_pkg::*;
  logic         pclk    = 1'b0;
  logic         presetn = 1'b0;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [7:0]   paddr   = 8'h00;
  logic [31:0]  pwdata  = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  asf_pin_in_t  pin_i;
  asf_pin_out_t pin_o;
  logic         p_bck;
  logic         p_ws;
  logic         p_sd;
  int           fail_count = 0;
  int           tests_run  = 0;
  int           cyc        = 0;

  always #10 pclk = ~pclk;

  // each line carries whichever side has its driver on
  assign pin_i = {pin_o.serial_bit_clock_oe ? pin_o.serial_bit_clock : p_bck,
                  pin_o.word_select_oe ? pin_o.word_select : p_ws,
                  pin_o.serial_data_line_oe ? pin_o.serial_data_line : p_sd};

  asf_top u_asf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o));

  asf_codec_model u_asf_codec_model (.pclk(pclk), .bck(pin_i.serial_bit_clock),
    .ws(pin_i.word_select), .sd(pin_i.serial_data_line), .mck(pin_o.master_clock_out),
    .p_bck(p_bck), .p_ws(p_ws), .p_sd(p_sd));

  task automatic results();
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1)
      fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // poll one status bit until set, under a bound
  task automatic wait_st(input int b, output logic [31:0] s);
    int n;
    n = 0;
    do begin
      rd(`ASF_OFF_STATUS, s);
      n++;
    end while (s[b] !== 1'b1 && n < 400);
    chk({31'h0, s[b]}, 32'h1);
  endtask

  function automatic logic [31:0] mk(input logic [1:0] s, input logic [1:0] d,
                                     input logic c, input logic p, input logic l, input logic m);
    mk = 32'h0;
    mk[`ASF_CTL_ENABLE] = 1'b1;
    mk[`ASF_CTL_STANDARD_SELECT +: 2] = s;
    mk[`ASF_CTL_DATA_LENGTH +: 2] = d;
    mk[`ASF_CTL_CHANNEL_LENGTH] = c;
    mk[`ASF_CTL_CLOCK_POLARITY] = p;
    mk[`ASF_CTL_PCM_SYNC_MODE] = l;
    mk[`ASF_CTL_MASTER] = m;
    mk[`ASF_CTL_TRANSMIT] = m;
    mk[`ASF_CTL_MCLK_ENABLE] = m;
  endfunction

  task automatic reset_case();
    logic [31:0] q;
    logic        e;
    chk({24'h0, pin_o}, 32'h0);
    rd(`ASF_OFF_AUDIO_CONTROL, q);
    chk(q, {21'h0, `ASF_CTL_RST});
    rd(`ASF_OFF_PRESCALE, q);
    chk(q, {24'h0, `ASF_PRESCALE_RST});
    rd(`ASF_OFF_STATUS, q);
    chk(q, 32'h1);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(`ASF_OFF_PRESCALE, 32'h0);
  endtask

  // master transmit, then find the words and framing on the line
  task automatic tx_case(input logic [31:0] c, input logic [15:0] w[4], input int nw,
                         input logic [63:0] pat, input int nb, input int o[3],
                         input logic v[3], input int mx);
    logic [31:0] s;
    int          n;
    int          idx;
    logic        hit;
    wr(`ASF_OFF_AUDIO_CONTROL, 32'h0);
    u_asf_codec_model.sd_hist.delete();
    u_asf_codec_model.ws_hist.delete();
    u_asf_codec_model.samp_rise = ~(c[6] ^ (c[2:1] == ASF_STD_PCM));
    // first half-word waits in the buffer so that slot 0 carries it
    wr(`ASF_OFF_DATA, {16'h0, w[0]});
    wr(`ASF_OFF_AUDIO_CONTROL, c);
    for (int i = 1; i < nw; i++) begin
      wait_st(`ASF_ST_TX_EMPTY, s);
      wr(`ASF_OFF_DATA, {16'h0, w[i]});
    end
    n = 0;
    while (u_asf_codec_model.sd_hist.size() < 200 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (u_asf_codec_model.sd_hist.size() < 200)
      fail_count++;
    hit = 1'b0;
    idx = 0;
    for (int k = 1; k + nb + 1 < u_asf_codec_model.sd_hist.size() && !hit; k++) begin
      hit = 1'b1;
      for (int j = 0; j < nb; j++)
        if (u_asf_codec_model.sd_hist[k + j] !== pat[63 - j])
          hit = 1'b0;
      if (hit)
        idx = k;
    end
    chk({31'h0, hit}, 32'h1);
    for (int i = 0; i < 3; i++)
      chk({31'h0, u_asf_codec_model.ws_hist[idx + o[i]]}, {31'h0, v[i]});
    chk({28'h0, pin_o.master_clock_oe, pin_o.serial_bit_clock_oe, pin_o.word_select_oe,
         pin_o.serial_data_line_oe}, 32'hF);
    chk(32'(u_asf_codec_model.mck_per_bit), 32'(mx));
  endtask

  // slave receive of one frame clocked by the codec
  task automatic rx_case(input logic [31:0] c, input logic [31:0] l, input logic [31:0] r,
                         input logic [15:0] x[4]);
    logic [31:0] s;
    logic [31:0] q;
    wr(`ASF_OFF_AUDIO_CONTROL, 32'h0);
    wr(`ASF_OFF_AUDIO_CONTROL, c);
    fork
      u_asf_codec_model.send_frame(l, r);
      for (int i = 0; i < 4; i++) begin
        wait_st(`ASF_ST_RX_FULL, s);
        chk({31'h0, s[`ASF_ST_CHANNEL]}, {31'h0, i > 1});
        rd(`ASF_OFF_DATA, q);
        chk(q, {16'h0, x[i]});
      end
    join
    @(posedge pclk);
    chk({28'h0, pin_o.master_clock_oe, pin_o.serial_bit_clock_oe, pin_o.word_select_oe,
         pin_o.serial_data_line_oe}, 32'h0);
  endtask

  // slave receive left unread: first word kept, overrun flagged and cleared
  task automatic ovr_case();
    logic [31:0] q;
    wr(`ASF_OFF_AUDIO_CONTROL, 32'h0);
    wr(`ASF_OFF_AUDIO_CONTROL, mk(2'h2, 2'h1, 1, 0, 0, 0));
    u_asf_codec_model.send_frame(32'hFFA1B2C3, 32'hFF5D6E7F);
    repeat (8) @(posedge pclk);
    rd(`ASF_OFF_STATUS, q);
    chk({29'h0, q[3:1]}, 32'h5);
    wr(`ASF_OFF_STATUS, 32'h8);
    rd(`ASF_OFF_STATUS, q);
    chk({31'h0, q[`ASF_ST_OVERRUN]}, 32'h0);
    rd(`ASF_OFF_DATA, q);
    chk(q, 32'h000000A1);
  endtask

  // cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_case();
    tx_case(mk(2'h0, 2'h0, 0, 0, 0, 1), '{16'hA5C3, 16'h3C96, 0, 0}, 2,
            64'hA5C33C96_00000000, 32, '{0, 15, 16}, '{0, 1, 1}, 8);
    tx_case(mk(2'h1, 2'h0, 0, 0, 0, 1), '{16'hA5C3, 16'h3C96, 0, 0}, 2,
            64'hA5C33C96_00000000, 32, '{0, 15, 16}, '{0, 0, 1}, 8);
    tx_case(mk(2'h1, 2'h2, 1, 1, 0, 1), '{16'h9A1B, 16'h2C3D, 16'hB4E5, 16'h06F7}, 4,
            64'h9A1B2C3D_B4E506F7, 64, '{0, 31, 32}, '{0, 0, 1}, 4);
    tx_case(mk(2'h2, 2'h1, 1, 0, 0, 1), '{16'hFFC1, 16'hD2E3, 16'hFF8F, 16'h9A0B}, 4,
            64'h00C1D2E3_008F9A0B, 64, '{0, 31, 32}, '{0, 0, 1}, 4);
    tx_case(mk(2'h0, 2'h1, 1, 0, 0, 1), '{16'hB1C2, 16'hD3FF, 16'h97A8, 16'hE9FF}, 4,
            64'hB1C2D300_97A8E900, 64, '{0, 31, 32}, '{0, 1, 1}, 4);
    tx_case(mk(2'h0, 2'h0, 1, 0, 0, 1), '{16'hC0DE, 16'h9BAD, 0, 0}, 2,
            64'hC0DE0000_9BAD0000, 64, '{0, 31, 32}, '{0, 1, 1}, 4);
    tx_case(mk(2'h3, 2'h0, 0, 0, 0, 1), '{16'h0000, 16'hB5A1, 0, 0}, 2,
            64'hB5A10000_00000000, 16, '{-1, 0, 1}, '{1, 0, 0}, 8);
    tx_case(mk(2'h3, 2'h2, 1, 1, 1, 1), '{16'h8123, 16'h4567, 0, 0}, 2,
            64'h81234567_00000000, 32, '{0, 12, 13}, '{1, 1, 0}, 4);
    rx_case(mk(2'h2, 2'h1, 1, 0, 0, 0), 32'hFFA1B2C3, 32'hFF5D6E7F,
            '{16'h00A1, 16'hB2C3, 16'h005D, 16'h6E7F});
    rx_case(mk(2'h1, 2'h1, 1, 0, 0, 0), 32'h1E2D3C5A, 32'h4B5A69A5,
            '{16'h1E2D, 16'h3C00, 16'h4B5A, 16'h6900});
    ovr_case();
    results();
  end
endmodule
